// >>> acc_pkg.sv
// Holds the constants shared by the conversion control block and its clock divider.
// Assumes a single system clock, an asynchronous active-high reset, and a plain register port.
package acc_pkg;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam int ADDR_W = 3;
  localparam logic [ADDR_W-1:0] OFS_RESULT = 3'h0;
  localparam logic [ADDR_W-1:0] OFS_CONTROL_A = 3'h1;
  localparam logic [ADDR_W-1:0] OFS_CONTROL_B = 3'h2;
  localparam logic [ADDR_W-1:0] OFS_PIN_SELECT = 3'h3;
  localparam logic [ADDR_W-1:0] OFS_IRQ_CTRL = 3'h4;
  localparam logic [ADDR_W-1:0] OFS_ENV_CTRL = 3'h5;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int CA_START_BIT = 7;
  localparam int CA_BUSY_BIT = 6;
  localparam int CA_POWER_OFF_BIT = 5;
  localparam int CA_CH_LO_MSB = 3;
  localparam int CB_CH_HI_BIT = 7;
  localparam int CB_BANDGAP_BIT = 6;
  localparam int CB_DIV_MSB = 2;
  localparam int IRQ_GLOBAL_BIT = 0;
  localparam int IRQ_ENABLE_BIT = 1;
  localparam int IRQ_REQUEST_BIT = 2;
  localparam int ENV_ENABLE_BIT = 0;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic RST_BUSY = 1'b1;
  localparam logic RST_POWER_OFF = 1'b1;
  localparam logic [3:0] RST_CH_LO = 4'h0;
  localparam logic RST_CH_HI = 1'b1;
  localparam logic RST_BANDGAP = 1'b1;
  localparam logic [2:0] RST_DIV_SEL = 3'h0;
  localparam logic [7:0] RST_PIN_SELECT = 8'hFF;
  localparam logic [7:0] RST_RESULT = 8'h00;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam logic [6:0] CONV_CLOCKS = 7'h6A;
  localparam logic [7:0] DIV_ALL_ONES = 8'hFF;
  localparam logic [2:0] DIV_TOP_CODE = 3'h7;

  // Sequencer states.
  typedef enum logic [1:0] {
    ACC_IDLE,
    ACC_HOLD,
    ACC_CONV
  } acc_state_t;

endpackage

// >>> acc_clk_div.sv
// Holds the conversion clock divider that makes one tick per conversion clock period.
// Assumes the sequencer clears it at every conversion trigger.
`timescale 1ns/1ns
module acc_clk_div (
  input wire logic clk,
  input wire logic rst,
  input wire logic sync_clr,
  input wire logic [2:0] div_sel,
  output logic tick
);
  import acc_pkg::*;

  logic [7:0] cnt_ff;
  logic tick_ff;
  logic [7:0] limit;

  // Period is two to the power of the select code plus one; the top code gives 256.
  assign limit = DIV_ALL_ONES >> (DIV_TOP_CODE - div_sel);

  // Counts system clocks and emits one tick at the end of each period.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_ff <= 8'h00;
      tick_ff <= 1'b0;
    end else if (sync_clr) begin
      cnt_ff <= 8'h00;
      tick_ff <= 1'b0;
    end else if (cnt_ff >= limit) begin
      cnt_ff <= 8'h00;
      tick_ff <= 1'b1;
    end else begin
      cnt_ff <= cnt_ff + 8'h01;
      tick_ff <= 1'b0;
    end
  end

  assign tick = tick_ff;

endmodule // acc_clk_div

// >>> acc_conv_ctrl.sv
// Holds the conversion control block: registers, start sequencer, pin overrides, interrupt gate.
// Assumes an external analog converter, an envelope unit and port logic around it.
//
// The strobed register port and the register addresses were decided locally.
`timescale 1ns/1ns
module acc_conv_ctrl (
  input wire logic clk,
  input wire logic rst,
  input wire logic [acc_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wr_data,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rd_data,
  input wire logic [7:0] conv_result_in,
  input wire logic env_tick_in,
  input wire logic [7:0] port_direction_reg,
  input wire logic [7:0] pull_high_req,
  output logic conv_reset,
  output logic conv_power_on,
  output logic conv_tick,
  output logic conv_done,
  output logic [4:0] conv_channel_sel,
  output logic bandgap_enable,
  output logic envelope_mode,
  output logic [7:0] analog_pin_enable,
  output logic [7:0] pin_pull_high_en,
  output logic [7:0] pin_direction_eff,
  output logic conv_irq
);
  import acc_pkg::*;

  // ************************************************************
  // Declarations
  // ************************************************************
  acc_state_t state_ff;
  acc_state_t nxt_state;
  logic start_ff;
  logic busy_ff;
  logic power_off_ff;
  logic [3:0] ch_lo_ff;
  logic ch_hi_ff;
  logic bandgap_ff;
  logic [2:0] div_sel_ff;
  logic [7:0] pin_select_ff;
  logic global_en_ff;
  logic irq_en_ff;
  logic irq_req_ff;
  logic env_en_ff;
  logic [7:0] result_ff;
  logic [6:0] tick_cnt_ff;
  logic [7:0] rd_data_ff;
  logic conv_reset_ff;
  logic conv_tick_ff;
  logic conv_done_ff;
  logic conv_irq_ff;
  logic conv_power_on_ff;
  logic [7:0] pull_high_ff;
  logic [7:0] dir_eff_ff;
  logic wr_ctrl_a;
  logic wr_ctrl_b;
  logic wr_pins;
  logic wr_irq;
  logic wr_env;
  logic start_new;
  logic start_rise;
  logic start_fall;
  logic div_tick;
  logic div_clr;
  logic last_tick;
  logic done_evt;

  // ************************************************************
  // Write decode
  // ************************************************************

  // One strobe per writable register; the bus never waits.
  assign wr_ctrl_a = reg_wr && (reg_addr == OFS_CONTROL_A);
  assign wr_ctrl_b = reg_wr && (reg_addr == OFS_CONTROL_B);
  assign wr_pins = reg_wr && (reg_addr == OFS_PIN_SELECT);
  assign wr_irq = reg_wr && (reg_addr == OFS_IRQ_CTRL);
  assign wr_env = reg_wr && (reg_addr == OFS_ENV_CTRL);

  // Start edges are seen only on writes; envelope mode makes the start bit inert.
  // A write of one counts as a rise anywhere but in the hold state, so a start bit
  // left high while the envelope unit ruled cannot swallow the next start.
  assign start_new = reg_wr_data[CA_START_BIT];
  assign start_rise = wr_ctrl_a && !env_en_ff && (state_ff != ACC_HOLD)
    && start_new;
  assign start_fall = wr_ctrl_a && !env_en_ff && start_ff && !start_new;

  // ************************************************************
  // Start sequencer
  // ************************************************************

  // The final tick of the count ends the conversion.
  assign last_tick = div_tick && (tick_cnt_ff == (CONV_CLOCKS - 7'h01));
  assign done_evt = (state_ff == ACC_CONV) && last_tick && !start_rise;

  // Restart the divider at the trigger so the first period is a whole one.
  assign div_clr = start_fall || (state_ff != ACC_CONV);

  // Chooses the next sequencer state; a new rising edge always wins.
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ACC_IDLE: begin
        if (start_rise) begin
          nxt_state = ACC_HOLD;
        end
      end
      ACC_HOLD: begin
        if (start_fall) begin
          nxt_state = ACC_CONV;
        end
      end
      ACC_CONV: begin
        if (start_rise) begin
          nxt_state = ACC_HOLD;
        end else if (last_tick) begin
          nxt_state = ACC_IDLE;
        end
      end
    endcase
    if (env_en_ff) begin
      nxt_state = ACC_IDLE;
    end
  end

  // Holds the sequencer state.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_ff <= ACC_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Counts conversion clock ticks from the trigger.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tick_cnt_ff <= 7'h00;
    end else if (state_ff != ACC_CONV) begin
      tick_cnt_ff <= 7'h00;
    end else if (div_tick) begin
      tick_cnt_ff <= tick_cnt_ff + 7'h01;
    end
  end

  // Divides the system clock down to the conversion clock.
  acc_clk_div u_div (
    .clk(clk),
    .rst(rst),
    .sync_clr(div_clr),
    .div_sel(div_sel_ff),
    .tick(div_tick)
  );

  // ************************************************************
  // First control register
  // ************************************************************

  // Stores the start bit, power control and low channel bits.
  // The power output has its own flip-flop so that no gate sits between it and the pin.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      start_ff <= 1'b0;
      power_off_ff <= RST_POWER_OFF;
      conv_power_on_ff <= !RST_POWER_OFF;
      ch_lo_ff <= RST_CH_LO;
    end else if (wr_ctrl_a) begin
      start_ff <= start_new;
      power_off_ff <= reg_wr_data[CA_POWER_OFF_BIT];
      conv_power_on_ff <= !reg_wr_data[CA_POWER_OFF_BIT];
      ch_lo_ff <= reg_wr_data[CA_CH_LO_MSB:0];
    end
  end

  // Busy rises with the start bit and falls only when a conversion completes.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busy_ff <= RST_BUSY;
    end else if (start_rise) begin
      busy_ff <= 1'b1;
    end else if (done_evt) begin
      busy_ff <= 1'b0;
    end
  end

  // Captures the converter output as busy clears; read-only to software.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      result_ff <= RST_RESULT;
    end else if (done_evt) begin
      result_ff <= conv_result_in;
    end
  end

  // ************************************************************
  // Second control register and pin select register
  // ************************************************************

  // Stores the top channel bit, bandgap enable and clock divide select.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ch_hi_ff <= RST_CH_HI;
      bandgap_ff <= RST_BANDGAP;
      div_sel_ff <= RST_DIV_SEL;
    end else if (wr_ctrl_b) begin
      ch_hi_ff <= reg_wr_data[CB_CH_HI_BIT];
      bandgap_ff <= reg_wr_data[CB_BANDGAP_BIT];
      div_sel_ff <= reg_wr_data[CB_DIV_MSB:0];
    end
  end

  // Stores the per-pin analog enables.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_select_ff <= RST_PIN_SELECT;
    end else if (wr_pins) begin
      pin_select_ff <= reg_wr_data;
    end
  end

  // ************************************************************
  // Interrupt and envelope control
  // ************************************************************

  // Stores the enables; the request flag sets on completion and a set beats a clear.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      global_en_ff <= 1'b0;
      irq_en_ff <= 1'b0;
      irq_req_ff <= 1'b0;
    end else begin
      if (wr_irq) begin
        global_en_ff <= reg_wr_data[IRQ_GLOBAL_BIT];
        irq_en_ff <= reg_wr_data[IRQ_ENABLE_BIT];
      end
      if (done_evt) begin
        irq_req_ff <= 1'b1;
      end else if (wr_irq) begin
        irq_req_ff <= reg_wr_data[IRQ_REQUEST_BIT];
      end
    end
  end

  // The request reaches the core only with both enables set.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      conv_irq_ff <= 1'b0;
    end else begin
      conv_irq_ff <= irq_req_ff && global_en_ff && irq_en_ff;
    end
  end

  // Stores the envelope unit takeover bit.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      env_en_ff <= 1'b0;
    end else if (wr_env) begin
      env_en_ff <= reg_wr_data[ENV_ENABLE_BIT];
    end
  end

  // ************************************************************
  // Converter drive
  // ************************************************************

  // Holds the converter in reset while the start bit stays high and passes clock ticks.
  // Done rises at the edge that clears busy, so it stands in the first cycle busy reads low.
  // The last conversion clock tick stands beside it in that same cycle.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      conv_reset_ff <= 1'b0;
      conv_tick_ff <= 1'b0;
      conv_done_ff <= 1'b0;
    end else begin
      conv_reset_ff <= (nxt_state == ACC_HOLD);
      conv_tick_ff <= env_en_ff ? env_tick_in : (div_tick && (state_ff == ACC_CONV));
      conv_done_ff <= done_evt;
    end
  end

  // ************************************************************
  // Pin overrides
  // ************************************************************

  // Each analog pin drops its pull-high and is forced to input direction.
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_pin
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          pull_high_ff[gi] <= 1'b0;
          dir_eff_ff[gi] <= 1'b1;
        end else begin
          pull_high_ff[gi] <= pull_high_req[gi] && !pin_select_ff[gi];
          dir_eff_ff[gi] <= port_direction_reg[gi] || pin_select_ff[gi];
        end
      end
    end
  endgenerate

  // ************************************************************
  // Read port
  // ************************************************************

  // Presents read data the cycle after the strobe; unmapped and reserved bits read zero.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_data_ff <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        OFS_RESULT: rd_data_ff <= result_ff;
        OFS_CONTROL_A: rd_data_ff <= {start_ff, busy_ff, power_off_ff, 1'b0, ch_lo_ff};
        OFS_CONTROL_B: rd_data_ff <= {ch_hi_ff, bandgap_ff, 3'h0, div_sel_ff};
        OFS_PIN_SELECT: rd_data_ff <= pin_select_ff;
        OFS_IRQ_CTRL: rd_data_ff <= {5'h00, irq_req_ff, irq_en_ff, global_en_ff};
        OFS_ENV_CTRL: rd_data_ff <= {7'h00, env_en_ff};
        default: rd_data_ff <= 8'h00;
      endcase
    end else begin
      rd_data_ff <= 8'h00;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************

  // All outputs come from flip-flops.
  assign reg_rd_data = rd_data_ff;
  assign conv_reset = conv_reset_ff;
  assign conv_power_on = conv_power_on_ff;
  assign conv_tick = conv_tick_ff;
  assign conv_done = conv_done_ff;
  assign conv_channel_sel = {ch_hi_ff, ch_lo_ff};
  assign bandgap_enable = bandgap_ff;
  assign envelope_mode = env_en_ff;
  assign analog_pin_enable = pin_select_ff;
  assign pin_pull_high_en = pull_high_ff;
  assign pin_direction_eff = dir_eff_ff;
  assign conv_irq = conv_irq_ff;

endmodule // acc_conv_ctrl

// >>> acc_conv_ctrl_props.sv
// Concurrent checks on the conversion control block's ports.
// Assumes one clock and an asynchronous active-high reset.
`timescale 1ns/1ns
module acc_conv_ctrl_props
  import acc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [acc_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wr_data,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rd_data,
  input wire logic [7:0] port_direction_reg,
  input wire logic [7:0] pull_high_req,
  input wire logic conv_reset,
  input wire logic conv_power_on,
  input wire logic conv_tick,
  input wire logic conv_done,
  input wire logic [4:0] conv_channel_sel,
  input wire logic envelope_mode,
  input wire logic [7:0] analog_pin_enable,
  input wire logic [7:0] pin_pull_high_en,
  input wire logic [7:0] pin_direction_eff,
  input wire logic conv_irq
);
  // ************************************************************
  // Helpers
  // ************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic [7:0] tick_cnt_ff;
  logic wr_a;
  // Counts conversion clock ticks since the last hold.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) tick_cnt_ff <= 8'h00;
    else if (conv_reset || envelope_mode) tick_cnt_ff <= 8'h00;
    else if (conv_tick) tick_cnt_ff <= tick_cnt_ff + 8'h01;
  end
  // Flags a write to the first control register.
  assign wr_a = reg_wr && (reg_addr == OFS_CONTROL_A);
  sequence s_start_set;
    wr_a && reg_wr_data[CA_START_BIT] && !envelope_mode;
  endsequence
  sequence s_start_clr;
    wr_a && !reg_wr_data[CA_START_BIT] && !envelope_mode;
  endsequence
  a_hold_resets: assert property (s_start_set |=> conv_reset)
    else $error("converter not held in reset after start set");
  a_tick_quiet: assert property (conv_reset && $past(conv_reset) && !envelope_mode |-> !conv_tick)
    else $error("conversion clock ticked during hold");
  a_launch_runs: assert property (s_start_set ##[1:2] s_start_clr |=> !conv_reset)
    else $error("start fall did not release converter");
  a_tick_count: assert property (conv_done |-> conv_tick && tick_cnt_ff == 8'h69)
    else $error("conversion did not last 106 ticks");
  a_power_bit: assert property (wr_a |=> conv_power_on == !$past(reg_wr_data[CA_POWER_OFF_BIT]))
    else $error("power control does not follow power-off bit");
  a_channel_low: assert property (wr_a |=> conv_channel_sel[3:0] == $past(reg_wr_data[3:0]))
    else $error("low channel bits not taken");
  a_channel_high: assert property (reg_wr && reg_addr == OFS_CONTROL_B |=>
    conv_channel_sel[4] == $past(reg_wr_data[CB_CH_HI_BIT]))
    else $error("top channel bit not taken");
  a_pin_override: assert property (pin_pull_high_en == $past(pull_high_req & ~analog_pin_enable) &&
    pin_direction_eff == $past(port_direction_reg | analog_pin_enable))
    else $error("pin override wrong");
  a_irq_gate: assert property (reg_wr && reg_addr == OFS_IRQ_CTRL &&
    !(reg_wr_data[IRQ_GLOBAL_BIT] && reg_wr_data[IRQ_ENABLE_BIT]) |=> ##1 !conv_irq)
    else $error("interrupt raised while disabled");
  a_busy_hold: assert property (reg_rd && reg_addr == OFS_CONTROL_A && conv_reset |=>
    reg_rd_data[CA_BUSY_BIT])
    else $error("busy not forced during hold");
endmodule // acc_conv_ctrl_props

bind acc_conv_ctrl acc_conv_ctrl_props u_props (.clk, .rst, .reg_addr, .reg_wr_data, .reg_wr,
  .reg_rd, .reg_rd_data, .port_direction_reg, .pull_high_req, .conv_reset, .conv_power_on,
  .conv_tick, .conv_done, .conv_channel_sel, .envelope_mode, .analog_pin_enable,
  .pin_pull_high_en, .pin_direction_eff, .conv_irq);

// >>> adc_conversion_control_tb_top.sv
// Self-checking bench for the conversion control block.
// Assumes the block's register port and a 10 MHz clock.
`timescale 1ns/1ns
`define CHK(n, e, a) begin tests_run++; if ((a) !== (e)) begin fail_count++; \
  $display("[ERR] %s exp %h got %h", n, e, a); end end
module adc_conversion_control_tb_top;
  import acc_pkg::*;
  // ************************************************************
  // Signals and instance
  // ************************************************************
  logic clk, rst, reg_wr, reg_rd, env_tick_in;
  logic [ADDR_W-1:0] reg_addr;
  logic [7:0] reg_wr_data, reg_rd_data, conv_result_in, port_direction_reg, pull_high_req;
  logic conv_reset, conv_power_on, conv_tick, conv_done, bandgap_enable, envelope_mode, conv_irq;
  logic [4:0] conv_channel_sel;
  logic [7:0] analog_pin_enable, pin_pull_high_en, pin_direction_eff;
  int fail_count = 0;
  int tests_run = 0;
  acc_conv_ctrl u_dut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wr_data(reg_wr_data),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rd_data(reg_rd_data), .conv_result_in(conv_result_in),
    .env_tick_in(env_tick_in), .port_direction_reg(port_direction_reg),
    .pull_high_req(pull_high_req), .conv_reset(conv_reset), .conv_power_on(conv_power_on),
    .conv_tick(conv_tick), .conv_done(conv_done), .conv_channel_sel(conv_channel_sel),
    .bandgap_enable(bandgap_enable), .envelope_mode(envelope_mode),
    .analog_pin_enable(analog_pin_enable), .pin_pull_high_en(pin_pull_high_en),
    .pin_direction_eff(pin_direction_eff), .conv_irq(conv_irq));
  // Makes the 100 ns clock.
  initial clk = 1'b0;
  always #50 clk = ~clk;
  // ************************************************************
  // Bus cycles and scenarios
  // ************************************************************
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wr_data <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the read edge.
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rd_data;
  endtask
  task automatic t_reset;
    logic [7:0] ex [6] = '{8'h60, 8'hC0, 8'hFF, 8'h00, 8'h00, 8'h00};
    logic [7:0] d;
    wr(3'h6, 8'hFF);
    for (int i = 1; i < 7; i++) begin
      rd(i[2:0], d);
      `CHK("reset reg", ex[i-1], d)
    end
    `CHK("power", 1'b0, conv_power_on)
  endtask
  task automatic t_pins;
    wr(OFS_PIN_SELECT, 8'h0F);
    port_direction_reg <= 8'h00;
    pull_high_req <= 8'hFF;
    repeat (2) @(posedge clk);
    #1 `CHK("pull", 8'hF0, pin_pull_high_en)
    `CHK("pins", 8'h0F, analog_pin_enable)
    `CHK("dir", 8'h0F, pin_direction_eff)
  endtask
  task automatic t_chan;
    wr(OFS_CONTROL_A, 8'h09);
    wr(OFS_CONTROL_B, 8'h40);
    #1 `CHK("chan", 5'h09, conv_channel_sel)
    `CHK("bandgap", 1'b1, bandgap_enable)
    wr(OFS_CONTROL_B, 8'h80);
    #1 `CHK("chan top", 5'h19, conv_channel_sel)
  endtask
  task automatic t_hold;
    logic [7:0] d;
    int k;
    wr(OFS_CONTROL_A, 8'h80);
    @(posedge clk);
    #1 `CHK("hold", 1'b1, conv_reset)
    rd(OFS_CONTROL_A, d);
    `CHK("busy hold", 8'hC0, d)
    wr(OFS_CONTROL_A, 8'h00);
    repeat (20) @(posedge clk);
    wr(OFS_CONTROL_A, 8'h80);
    rd(OFS_CONTROL_A, d);
    `CHK("busy abort", 8'hC0, d)
    k = 0;
    repeat (300) begin
      @(posedge clk);
      #1 k += conv_done;
    end
    `CHK("no done", 0, k)
  endtask
  task automatic t_conv(input logic [2:0] dv);
    int p, n, tk;
    logic [7:0] d;
    p = 2 << dv;
    wr(OFS_CONTROL_A, 8'h00);
    wr(OFS_CONTROL_B, {5'h00, dv});
    conv_result_in <= 8'hA0 + dv;
    wr(OFS_CONTROL_A, 8'h80);
    wr(OFS_CONTROL_A, 8'h00);
    n = 0;
    tk = 0;
    do begin
      @(posedge clk);
      #1 n++;
      tk += conv_tick;
    end while (!conv_done && n < 30000);
    `CHK("conv time", 1'b1, n >= 106 * p && n <= 106 * p + 3)
    `CHK("ticks", 106, tk)
    rd(OFS_CONTROL_A, d);
    `CHK("busy end", 8'h00, d)
    rd(OFS_RESULT, d);
    `CHK("result", 8'hA0 + dv, d)
  endtask
  task automatic t_irq;
    logic [7:0] d;
    wr(OFS_IRQ_CTRL, 8'h03);
    t_conv(3'h0);
    `CHK("irq on", 1'b1, conv_irq)
    wr(OFS_IRQ_CTRL, 8'h03);
    @(posedge clk);
    #1 `CHK("irq clear", 1'b0, conv_irq)
    wr(OFS_IRQ_CTRL, 8'h01);
    t_conv(3'h0);
    `CHK("irq masked", 1'b0, conv_irq)
    rd(OFS_IRQ_CTRL, d);
    `CHK("irq flag", 8'h05, d)
  endtask
  task automatic t_env;
    logic [7:0] d;
    wr(OFS_ENV_CTRL, 8'h01);
    wr(OFS_CONTROL_A, 8'h80);
    @(posedge clk);
    #1 `CHK("env start", 1'b0, conv_reset)
    `CHK("env mode", 1'b1, envelope_mode)
    @(posedge clk);
    env_tick_in <= 1'b1;
    @(posedge clk);
    env_tick_in <= 1'b0;
    #1 `CHK("env tick", 1'b1, conv_tick)
    rd(OFS_CONTROL_A, d);
    `CHK("env busy", 1'b0, d[CA_BUSY_BIT])
  endtask
  // ************************************************************
  // Sequence, watchdog and verdict
  // ************************************************************
  task automatic finish_test;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Runs the scenarios in order after reset.
  initial begin
    rst = 1'b1;
    {reg_wr, reg_rd, env_tick_in} = 3'h0;
    reg_addr = 3'h0;
    reg_wr_data = 8'h00;
    conv_result_in = 8'h00;
    port_direction_reg = 8'hFF;
    pull_high_req = 8'h00;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_pins();
    t_chan();
    t_hold();
    for (int i = 0; i < 8; i++) t_conv(i[2:0]);
    t_irq();
    t_env();
    finish_test();
  end
  // Cuts a hang short well past the expected run length.
  initial begin
    repeat (90000) @(posedge clk);
    fail_count++;
    finish_test();
  end
endmodule // adc_conversion_control_tb_top
